/* stack_rotate_instruction_unit.sv */
/*
  Execution unit for pop, push, subroutine return, carry clear and the three
  one-bit rotates, with a classic Wishbone slave for stack pointer, flags,
  program counter and status.
  Assumes the register file answers a read with data one clock after MEM_RD,
  and that the fetch path holds INSN_VALID until INSN_READY is seen high.
*/
// The implementer's own choices: the Wishbone slave port and the register offsets.
module stack_rotate_instruction_unit
  import stack_rotate_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // instruction from decode
  input wire logic INSN_VALID,
  input wire logic [7:0] INSN_OPCODE,
  input wire logic [7:0] INSN_OPERAND,
  output logic INSN_READY,
  output logic INSN_DONE,
  // register file and stack memory
  output logic [7:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  // program counter and flags to the core
  output logic PROGRAM_COUNTER_LOAD,
  output logic [15:0] PROGRAM_COUNTER_VALUE,
  output logic [7:0] FLAGS
);
  import stack_rotate_pkg::*;

  // opcode to class
  function automatic op_class_e decode(input logic [7:0] opc);
    unique case (opc)
      OPC_POP, OPC_POP_IND: decode = CL_POP;
      OPC_PUSH, OPC_PUSH_IND: decode = CL_PUSH;
      OPC_RETURN: decode = CL_RETURN;
      OPC_CARRY_CLEAR: decode = CL_CARRY_CLEAR;
      OPC_ROT_LEFT, OPC_ROT_LEFT_IND: decode = CL_ROT_LEFT;
      OPC_ROT_LEFT_CARRY, OPC_ROT_LEFT_CARRY_IND: decode = CL_ROT_LEFT_CARRY;
      OPC_ROT_RIGHT, OPC_ROT_RIGHT_IND: decode = CL_ROT_RIGHT;
      default: decode = CL_NONE;
    endcase
  endfunction

  // carry out in bit 8, rotated byte below it
  function automatic logic [8:0] rotate(input op_class_e c, input logic [7:0] v, input logic cin);
    unique case (c)
      CL_ROT_LEFT: rotate = {v[7], v[6:0], v[7]};
      CL_ROT_LEFT_CARRY: rotate = {v[7], v[6:0], cin};
      CL_ROT_RIGHT: rotate = {v[0], v[0], v[7:1]};
      default: rotate = {cin, v};
    endcase
  endfunction

  seq_state_e state;
  op_class_e cls;
  op_class_e dec;
  logic [3:0] cnt;
  logic [3:0] len;
  logic ind;
  logic [7:0] opnd;
  logic [7:0] ptr;
  logic [7:0] data;
  logic [7:0] stack_pointer;
  logic [7:0] flags;
  logic [15:0] program_counter;
  logic bad_op;
  logic accept;
  logic last;
  logic is_rot;
  logic [8:0] rot;
  logic wb_req;
  logic wb_wr;

  assign dec = decode(INSN_OPCODE);
  assign INSN_READY = (state == ST_IDLE);
  assign accept = INSN_READY && INSN_VALID && (dec != CL_NONE);
  assign len = (cls == CL_CARRY_CLEAR || is_rot) ? LEN_SHORT : LEN_STACK;
  assign last = (state == ST_RUN) && (cnt == len - 4'h1);
  assign is_rot = (cls == CL_ROT_LEFT) || (cls == CL_ROT_LEFT_CARRY) || (cls == CL_ROT_RIGHT);
  assign rot = rotate(cls, MEM_RDATA, flags[FLAG_C]);
  assign INSN_DONE = last;
  assign FLAGS = flags;
  assign PROGRAM_COUNTER_VALUE = program_counter;
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // a write lands at the edge where the master sees ack, so an aborted cycle changes nothing
  assign wb_wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];

  // sequencer: one instruction at a time, fixed length per class
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      cls <= CL_NONE;
      cnt <= 4'h0;
      ind <= 1'b0;
      opnd <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_RUN;
            cls <= dec;
            ind <= INSN_OPCODE[0];
            opnd <= INSN_OPERAND;
            cnt <= 4'h0;
          end
        end
        ST_RUN: begin
          if (last) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // operand pointer and data latches; return reuses ptr for the high byte
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ptr <= 8'h00;
      data <= 8'h00;
    end else if (state == ST_RUN) begin
      if (cnt == STEP_LATCH_PTR) begin
        if (cls == CL_RETURN) begin
          ptr <= MEM_RDATA;
        end else begin
          ptr <= ind ? MEM_RDATA : opnd;
        end
      end
      if (cnt == STEP_LATCH_DATA) begin
        data <= MEM_RDATA;
      end
    end
  end

  // memory port, decoded from the registered step so it is glitch-free per cycle;
  // rotate write data comes straight from the read data to save a cycle
  always_comb begin
    MEM_ADDR = 8'h00;
    MEM_RD = 1'b0;
    MEM_WR = 1'b0;
    MEM_WDATA = 8'h00;
    if (state == ST_RUN) begin
      if (cls == CL_RETURN) begin
        if (cnt == STEP_FETCH_PTR) begin
          MEM_RD = 1'b1;
          MEM_ADDR = stack_pointer;
        end
        if (cnt == STEP_READ) begin
          MEM_RD = 1'b1;
          MEM_ADDR = stack_pointer + 8'h01;
        end
      end else if (cls != CL_CARRY_CLEAR) begin
        if (cnt == STEP_FETCH_PTR) begin
          MEM_RD = 1'b1;
          MEM_ADDR = opnd;
        end
        if (cnt == STEP_READ) begin
          MEM_RD = 1'b1;
          MEM_ADDR = (cls == CL_POP) ? stack_pointer : ptr;
        end
        if (cls == CL_POP && cnt == STEP_FOUR) begin
          MEM_WR = 1'b1;
          MEM_ADDR = ptr;
          MEM_WDATA = data;
        end
        if (cls == CL_PUSH && cnt == STEP_FIVE) begin
          MEM_WR = 1'b1;
          MEM_ADDR = stack_pointer;
          MEM_WDATA = data;
        end
        if (is_rot && cnt == STEP_LATCH_DATA) begin
          MEM_WR = 1'b1;
          MEM_ADDR = ptr;
          MEM_WDATA = rot[7:0];
        end
      end
    end
  end

  // stack pointer: hardware step wins over a bus write in the same cycle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stack_pointer <= STACK_POINTER_RESET;
    end else if (state == ST_RUN && cls == CL_POP && cnt == STEP_FIVE) begin
      stack_pointer <= stack_pointer + 8'h01;
    end else if (state == ST_RUN && cls == CL_PUSH && cnt == STEP_FOUR) begin
      stack_pointer <= stack_pointer - 8'h01;
    end else if (state == ST_RUN && cls == CL_RETURN && cnt == STEP_FIVE) begin
      stack_pointer <= stack_pointer + 8'h02;
    end else if (wb_wr && WB_ADR_I == REG_STACK_POINTER) begin
      stack_pointer <= WB_DAT_I[7:0];
    end
  end

  // flags: only rotates, carry clear and a bus write to the flags register touch them
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags <= FLAGS_RESET;
    end else if (state == ST_RUN && is_rot && cnt == STEP_LATCH_DATA) begin
      flags[FLAG_C] <= rot[8];
      flags[FLAG_Z] <= (rot[7:0] == 8'h00);
      flags[FLAG_S] <= rot[7];
      flags[FLAG_V] <= rot[7] ^ MEM_RDATA[7];
    end else if (state == ST_RUN && cls == CL_CARRY_CLEAR && cnt == STEP_LATCH_DATA) begin
      flags[FLAG_C] <= 1'b0;
    end else if (wb_wr && WB_ADR_I == REG_FLAGS) begin
      flags <= WB_DAT_I[7:0];
    end
  end

  // program counter load from the two stacked bytes
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      program_counter <= PROGRAM_COUNTER_RESET;
      PROGRAM_COUNTER_LOAD <= 1'b0;
    end else begin
      PROGRAM_COUNTER_LOAD <= 1'b0;
      if (state == ST_RUN && cls == CL_RETURN && cnt == STEP_FOUR) begin
        program_counter <= {ptr, data};
        PROGRAM_COUNTER_LOAD <= 1'b1;
      end
    end
  end

  // sticky bad opcode; a new refusal beats a write-one clear
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bad_op <= 1'b0;
    end else if (INSN_READY && INSN_VALID && dec == CL_NONE) begin
      bad_op <= 1'b1;
    end else if (wb_wr && WB_ADR_I == REG_STATUS && WB_DAT_I[STAT_BAD_OP]) begin
      bad_op <= 1'b0;
    end
  end

  // bus answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          REG_STACK_POINTER: WB_DAT_O <= {24'h00_0000, stack_pointer};
          REG_FLAGS: WB_DAT_O <= {24'h00_0000, flags};
          REG_PROGRAM_COUNTER: WB_DAT_O <= {16'h0000, program_counter};
          REG_STATUS: WB_DAT_O <= {30'h0000_0000, bad_op, state == ST_RUN};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_return_reads;
    ##1 (MEM_RD && MEM_ADDR == stack_pointer) ##2 (MEM_RD && MEM_ADDR == stack_pointer + 8'h01);
  endsequence

  // read at c2 answers in c3, so the c4 write carries the value one cycle back
  sequence s_pop_steps;
    ##3 (MEM_RD && MEM_ADDR == stack_pointer) ##2 (MEM_WR && MEM_WDATA == $past(MEM_RDATA, 1));
  endsequence

  property p_pop;
    accept && dec == CL_POP && !WB_CYC_I |-> s_pop_steps
      ##3 (stack_pointer == $past(stack_pointer, 8) + 8'h01 && flags == $past(flags, 8));
  endproperty
  a_pop: assert property (p_pop) else $error("pop order or pointer wrong");

  property p_push;
    state == ST_RUN && cls == CL_PUSH && cnt == STEP_FIVE |-> MEM_WR && MEM_ADDR == $past(stack_pointer, 2) - 8'h01
      && MEM_WDATA == $past(MEM_RDATA, 2) && flags == $past(flags, 5);
  endproperty
  a_push: assert property (p_push) else $error("push wrote wrong place");

  property p_carry_clear;
    accept && dec == CL_CARRY_CLEAR && !WB_CYC_I |-> ##5 (!flags[FLAG_C] && flags[6:0] == $past(flags[6:0], 5));
  endproperty
  a_carry_clear: assert property (p_carry_clear) else $error("carry clear wrong");

  property p_return;
    accept && dec == CL_RETURN && !WB_CYC_I |-> s_return_reads ##3 (PROGRAM_COUNTER_LOAD
      && PROGRAM_COUNTER_VALUE == {$past(MEM_RDATA, 4), $past(MEM_RDATA, 2)})
      ##2 (stack_pointer == $past(stack_pointer, 8) + 8'h02 && INSN_DONE);
  endproperty
  a_return: assert property (p_return) else $error("return load wrong");

  property p_rot_left;
    state == ST_RUN && cls == CL_ROT_LEFT && cnt == STEP_LATCH_DATA |-> MEM_WDATA == {MEM_RDATA[6:0], MEM_RDATA[7]}
      ##1 flags[FLAG_C] == $past(MEM_RDATA[7]);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_rot_left_carry;
    state == ST_RUN && cls == CL_ROT_LEFT_CARRY && cnt == STEP_LATCH_DATA
      |-> MEM_WDATA == {MEM_RDATA[6:0], flags[FLAG_C]} ##1 flags[FLAG_C] == $past(MEM_RDATA[7]);
  endproperty
  a_rot_left_carry: assert property (p_rot_left_carry) else $error("rotate through carry wrong");

  property p_rot_right;
    state == ST_RUN && cls == CL_ROT_RIGHT && cnt == STEP_LATCH_DATA |-> MEM_WDATA == {MEM_RDATA[0], MEM_RDATA[7:1]}
      ##1 flags[FLAG_C] == $past(MEM_RDATA[0]);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_rot_flags;
    MEM_WR && state == ST_RUN && is_rot |=> flags[FLAG_Z] == ($past(MEM_WDATA) == 8'h00)
      && flags[FLAG_S] == $past(MEM_WDATA[7]) && $stable(flags[FLAG_D]) && $stable(flags[FLAG_H]);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate zero or sign wrong");

  property p_rot_ovf;
    MEM_WR && state == ST_RUN && is_rot |=> flags[FLAG_V] == ($past(MEM_RDATA[7]) ^ $past(MEM_WDATA[7]));
  endproperty
  a_rot_ovf: assert property (p_rot_ovf) else $error("rotate overflow wrong");

  property p_indirect;
    state == ST_RUN && is_rot && cnt == STEP_READ |-> MEM_RD && MEM_ADDR == (ind ? $past(MEM_RDATA) : opnd);
  endproperty
  a_indirect: assert property (p_indirect) else $error("operand address wrong");

  property p_wrap;
    state == ST_RUN && cls == CL_PUSH && cnt == STEP_FOUR && stack_pointer == 8'h00 |=> stack_pointer == 8'hff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stack pointer did not wrap");
endmodule

/* stack_rotate_pkg.sv */
/*
  Shared constants for the stack, return, carry-clear and rotate execution unit:
  opcodes, instruction lengths, step numbers, flag positions, register offsets.
  Assumes one 8-bit register space that holds both the working registers and the stack.
*/
// Operation
// - pop reads byte at stack pointer into destination, then increments pointer; flags kept
// - push decrements stack pointer first, then writes source byte there; flags kept
// - carry clear forces carry to zero, leaves every other flag alone
// - return loads program counter from stack, adds two to pointer, flags kept
// - return takes high byte at pointer, low byte at pointer plus one
// - rotate left: bit 7 goes to bit 0 and to carry
// - rotate left through carry: old carry to bit 0, old bit 7 to carry
// - rotate right: bit 0 goes to bit 7 and to carry
// - rotates set zero on zero result, sign from bit 7, keep decimal and half-carry
// - rotates set overflow when bit 7 changes, clear it otherwise
package stack_rotate_pkg;
  // opcodes; bit 0 selects the indirect form where one exists
  localparam logic [7:0] OPC_POP = 8'h50;
  localparam logic [7:0] OPC_POP_IND = 8'h51;
  localparam logic [7:0] OPC_PUSH = 8'h70;
  localparam logic [7:0] OPC_PUSH_IND = 8'h71;
  localparam logic [7:0] OPC_CARRY_CLEAR = 8'hcf;
  localparam logic [7:0] OPC_RETURN = 8'haf;
  localparam logic [7:0] OPC_ROT_LEFT = 8'h90;
  localparam logic [7:0] OPC_ROT_LEFT_IND = 8'h91;
  localparam logic [7:0] OPC_ROT_LEFT_CARRY = 8'h10;
  localparam logic [7:0] OPC_ROT_LEFT_CARRY_IND = 8'h11;
  localparam logic [7:0] OPC_ROT_RIGHT = 8'he0;
  localparam logic [7:0] OPC_ROT_RIGHT_IND = 8'he1;

  // cycle counts per instruction
  localparam logic [3:0] LEN_STACK = 4'h8;
  localparam logic [3:0] LEN_SHORT = 4'h4;

  // step numbers inside an instruction
  localparam logic [3:0] STEP_FETCH_PTR = 4'h0;
  localparam logic [3:0] STEP_LATCH_PTR = 4'h1;
  localparam logic [3:0] STEP_READ = 4'h2;
  localparam logic [3:0] STEP_LATCH_DATA = 4'h3;
  localparam logic [3:0] STEP_FOUR = 4'h4;
  localparam logic [3:0] STEP_FIVE = 4'h5;

  // flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // reset values
  localparam logic [7:0] STACK_POINTER_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PROGRAM_COUNTER_RESET = 16'h0000;

  // register byte offsets on the bus
  localparam logic [7:0] REG_STACK_POINTER = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_PROGRAM_COUNTER = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD_OP = 1;

  // instruction classes, one-hot
  typedef enum logic [7:0] {
    CL_NONE = 8'h01,
    CL_POP = 8'h02,
    CL_PUSH = 8'h04,
    CL_RETURN = 8'h08,
    CL_CARRY_CLEAR = 8'h10,
    CL_ROT_LEFT = 8'h20,
    CL_ROT_LEFT_CARRY = 8'h40,
    CL_ROT_RIGHT = 8'h80
  } op_class_e;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } seq_state_e;
endpackage

/* regfile_model.sv */
/*
  Behavioural register file and stack memory that faces the execution unit.
  Assumes one clock and that a read strobe is answered with data one clock later.
*/
module regfile_model (
  // clock
  input wire logic clk,
  // access port
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] q = 8'h00;
  logic q_valid = 1'b0;

  // plain always so the bench may preload cells between instructions
  always @(posedge clk) begin
    q_valid <= rd;
    if (rd) begin
      q <= mem[addr];
    end
    if (wr) begin
      mem[addr] <= wdata;
    end
  end

  // data stands one cycle only; the inverse afterwards exposes late sampling
  assign rdata = q_valid ? q : ~q;
endmodule

/* stack_rotate_instruction_unit_tb.sv */
/*
  Self-checking bench for the stack, return, carry-clear and rotate unit.
  Assumes the register file model beside it and the bus offsets of the package.
*/
`define CHECK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end

module stack_rotate_instruction_unit_tb;
  import stack_rotate_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic INSN_VALID = 1'b0;
  logic [7:0] INSN_OPCODE = 8'h00;
  logic [7:0] INSN_OPERAND = 8'h00;
  logic INSN_READY, INSN_DONE, MEM_RD, MEM_WR, PROGRAM_COUNTER_LOAD;
  logic [7:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, FLAGS;
  logic [15:0] PROGRAM_COUNTER_VALUE;
  int checks = 0;
  int error_cnt = 0;
  logic [7:0] rot_opc [6] = '{8'h90, 8'h91, 8'h10, 8'h11, 8'he0, 8'he1};
  logic [7:0] rot_val [6] = '{8'haa, 8'h17, 8'haa, 8'h80, 8'h31, 8'h00};
  logic rot_cin [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [8:0] r;

  // half period of the 40 MHz core clock
  always #12.5 CORE_CLK = ~CORE_CLK;

  stack_rotate_instruction_unit dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .INSN_VALID(INSN_VALID),
    .INSN_OPCODE(INSN_OPCODE), .INSN_OPERAND(INSN_OPERAND), .INSN_READY(INSN_READY),
    .INSN_DONE(INSN_DONE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .PROGRAM_COUNTER_LOAD(PROGRAM_COUNTER_LOAD),
    .PROGRAM_COUNTER_VALUE(PROGRAM_COUNTER_VALUE),
    .FLAGS(FLAGS));

  regfile_model regs (.clk(CORE_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
    .wdata(MEM_WDATA), .rdata(MEM_RDATA));

  // one classic cycle; held until ack is seen, then released for a cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= wd;
    @(posedge CORE_CLK);
    while (WB_ACK_O !== 1'b1) @(posedge CORE_CLK);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    wb(1'b1, adr, wd, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    `CHECK(nm, exp, d)
  endtask

  // offer one instruction and count cycles from acceptance to done
  task automatic run(input logic [7:0] opc, input logic [7:0] opnd, input int len);
    int n;
    INSN_VALID <= 1'b1;
    INSN_OPCODE <= opc;
    INSN_OPERAND <= opnd;
    @(negedge CORE_CLK);
    while (INSN_READY !== 1'b1) @(negedge CORE_CLK);
    @(posedge CORE_CLK);
    INSN_VALID <= 1'b0;
    n = 0;
    do begin
      @(negedge CORE_CLK);
      n++;
    end while (INSN_DONE !== 1'b1 && n < 20);
    `CHECK("cycles", len, n)
    // for rotates and carry clear the last edge writes memory or flags; one more edge lets them settle before checks
    @(posedge CORE_CLK);
    @(posedge CORE_CLK);
  endtask

  // carry out in bit 8, result below
  function automatic logic [8:0] rot(input logic [7:0] opc, input logic [7:0] v, input logic c);
    case (opc[7:4])
      4'h9: return {v[7], v[6:0], v[7]};
      4'h1: return {v[7], v[6:0], c};
      default: return {v[0], v[0], v[7:1]};
    endcase
  endfunction

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang counts as a failure; the whole run needs well under this
  initial begin
    repeat (6000) @(posedge CORE_CLK);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    @(posedge CORE_CLK);
    rdc("stack pointer", REG_STACK_POINTER, {24'h0, STACK_POINTER_RESET});
    rdc("flags", REG_FLAGS, {24'h0, FLAGS_RESET});
    rdc("counter", REG_PROGRAM_COUNTER, {16'h0, PROGRAM_COUNTER_RESET});
    rdc("status", REG_STATUS, 32'h0);
    rdc("unmapped", 8'h10, 32'h0);
    test_end("reset");
    // pop: register form, then indirect form
    regs.mem[8'h00] = 8'h01;
    regs.mem[8'hbb] = 8'h55;
    regs.mem[8'hbc] = 8'h66;
    wr(REG_STACK_POINTER, 32'hbb);
    wr(REG_FLAGS, 32'hfc);
    run(OPC_POP, 8'h00, 8);
    `CHECK("pop dst", 8'h55, regs.mem[8'h00])
    rdc("pop pointer", REG_STACK_POINTER, 32'hbc);
    regs.mem[8'h00] = 8'h01;
    run(OPC_POP_IND, 8'h00, 8);
    `CHECK("pop ind", 8'h66, regs.mem[8'h01])
    `CHECK("pop ptr", 8'h01, regs.mem[8'h00])
    rdc("pop ind pointer", REG_STACK_POINTER, 32'hbd);
    test_end("pop");
    // push from pointer zero wraps downward
    regs.mem[8'h40] = 8'h4f;
    regs.mem[8'h4f] = 8'haa;
    wr(REG_STACK_POINTER, 32'h00);
    run(OPC_PUSH, 8'h40, 8);
    `CHECK("push", 8'h4f, regs.mem[8'hff])
    run(OPC_PUSH_IND, 8'h40, 8);
    `CHECK("push ind", 8'haa, regs.mem[8'hfe])
    rdc("push pointer", REG_STACK_POINTER, 32'hfe);
    test_end("push");
    // return straddling the top of the space
    regs.mem[8'hff] = 8'h10;
    regs.mem[8'h00] = 8'h1a;
    wr(REG_STACK_POINTER, 32'hff);
    run(OPC_RETURN, 8'h00, 8);
    `CHECK("counter port", 16'h101a, PROGRAM_COUNTER_VALUE)
    rdc("return pointer", REG_STACK_POINTER, 32'h01);
    wr(REG_PROGRAM_COUNTER, 32'hffff);
    rdc("counter kept", REG_PROGRAM_COUNTER, 32'h101a);
    rdc("stack flags", REG_FLAGS, 32'hfc);
    test_end("return");
    wr(REG_FLAGS, 32'hff);
    run(OPC_CARRY_CLEAR, 8'h00, 4);
    rdc("ccf", REG_FLAGS, 32'h7f);
    test_end("carry clear");
    // rotates: even entries name cell 2 directly, odd entries reach it through cell 1
    for (int i = 0; i < 6; i++) begin
      regs.mem[8'h01] = 8'h02;
      regs.mem[8'h02] = rot_val[i];
      wr(REG_FLAGS, {24'h0, rot_cin[i], 7'h7c});
      run(rot_opc[i], 8'h02 - {7'h0, rot_opc[i][0]}, 4);
      r = rot(rot_opc[i], rot_val[i], rot_cin[i]);
      `CHECK("rot res", r[7:0], regs.mem[8'h02])
      `CHECK("rot ptr", 8'h02, regs.mem[8'h01])
      `CHECK("rot flags", {r[8], r[7:0] == 8'h0, r[7], r[7] ^ rot_val[i][7], 4'hc}, FLAGS)
    end
    test_end("rotate");
    INSN_VALID <= 1'b1;
    INSN_OPCODE <= 8'h00;
    repeat (3) @(posedge CORE_CLK);
    INSN_VALID <= 1'b0;
    `CHECK("ready", 1'b1, INSN_READY)
    @(posedge CORE_CLK);
    rdc("bad op", REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'h2);
    rdc("bad op clr", REG_STATUS, 32'h0);
    test_end("bad opcode");
    print_verdict();
  end
endmodule
